// File: qdc_top.sv
// Top of the quad converter control: code registers, output latches, power modes.
// Assumes the host keeps the serial link rules; analog parts lie outside.
`timescale 1ns/1ps
`default_nettype none
module qdc_top #(
    parameter int WAKE_CYCLES = qdc_pkg::WAKE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic frame_sel_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    output logic [4*qdc_pkg::CODE_BITS-1:0] out_code_o,
    output logic powered_down_o,
    output qdc_pkg::qdc_term_t term_o,
    output logic outputs_valid_o,
    output logic frame_done_o,
    output logic frame_abort_o
);
    localparam int NCH = qdc_pkg::NUM_CH;
    localparam int CW = qdc_pkg::CODE_BITS;
    initial begin
        if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) $error("WAKE_CYCLES out of range");
    end
    qdc_pkg::qdc_frame_t frame;
    logic done;
    logic [CW-1:0] code_q [NCH];
    logic [CW-1:0] latch_q [NCH];
    logic pd_q;
    qdc_pkg::qdc_term_t term_q;
    logic [15:0] wake_q;
    logic wrote_q;
    qdc_frame_rx #(
        .FRAME_LEN(qdc_pkg::FRAME_BITS)
    ) u_rx (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .frame_sel_n_i(frame_sel_n_i),
        .serial_clk_i(serial_clk_i),
        .serial_data_i(serial_data_i),
        .frame_done_o(done),
        .frame_o(frame),
        .frame_abort_o(frame_abort_o)
    );
    assign frame_done_o = done;
    function automatic qdc_pkg::qdc_term_t term_of(input logic [1:0] sel);
        unique case (sel)
            2'h1: term_of = qdc_pkg::QDC_TERM_2K5;
            2'h2: term_of = qdc_pkg::QDC_TERM_100K;
            default: term_of = qdc_pkg::QDC_TERM_HIZ;
        endcase
    endfunction : term_of
    // ==================================================
    // Code registers and output latches
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    code_q[g] <= qdc_pkg::CODE_RESET;
                    latch_q[g] <= qdc_pkg::CODE_RESET;
                end else if (clk_en_i && done) begin
                    unique case (frame.mode)
                        qdc_pkg::QDC_LOAD_ONLY: begin
                            if (frame.channel_select == 2'(g)) code_q[g] <= frame.code;
                        end
                        qdc_pkg::QDC_LOAD_UPDATE: begin
                            if (frame.channel_select == 2'(g)) begin
                                code_q[g] <= frame.code;
                                latch_q[g] <= frame.code;
                            end else begin
                                latch_q[g] <= code_q[g];
                            end
                        end
                        qdc_pkg::QDC_LOAD_ALL: begin
                            code_q[g] <= frame.code;
                            latch_q[g] <= frame.code;
                        end
                        qdc_pkg::QDC_POWER_DOWN: begin
                        end
                    endcase
                end
            end
            assign out_code_o[g*CW +: CW] = latch_q[g];
        end
    endgenerate
    // ==================================================
    // Power-down and wake
    // power mode and wake counter
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_q <= 1'b0;
            term_q <= qdc_pkg::QDC_TERM_HIZ;
            wake_q <= 16'h0000;
        end else if (clk_en_i) begin
            if (done && frame.mode == qdc_pkg::QDC_POWER_DOWN) begin
                pd_q <= 1'b1;
                term_q <= term_of(frame.channel_select);
                wake_q <= 16'h0000;
            end else if (done && pd_q) begin
                pd_q <= 1'b0;
                wake_q <= 16'(WAKE_CYCLES);
            end else if (wake_q != 16'h0000) begin
                wake_q <= wake_q - 16'h0001;
            end
        end
    end
    // outputs held at zero until first valid frame
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wrote_q <= 1'b0;
        end else if (clk_en_i && done) begin
            wrote_q <= 1'b1;
        end
    end
    assign powered_down_o = pd_q;
    assign term_o = term_q;
    assign outputs_valid_o = wrote_q && !pd_q && wake_q == 16'h0000;
    // ==================================================
    // Assertions on frame execution
    logic pd_cmd;
    logic ld_cmd;
    assign ld_cmd = clk_en_i && done;
    assign pd_cmd = ld_cmd && frame.mode == qdc_pkg::QDC_POWER_DOWN;
    chk_pd_keeps_code: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> $stable(code_q[0]))
        else $error("power-down changed a code register");
    chk_pd_keeps_code1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> $stable(code_q[1]))
        else $error("power-down changed code register one");
    chk_pd_keeps_code2: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> $stable(code_q[2]))
        else $error("power-down changed code register two");
    chk_pd_keeps_code3: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> $stable(code_q[3]))
        else $error("power-down changed code register three");
    chk_pd_keeps_latch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> $stable(latch_q[1]))
        else $error("power-down moved an output latch");
    chk_pd_entry: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_cmd |=> pd_q)
        else $error("power-down not entered");
    chk_pd_term: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (pd_cmd && frame.channel_select == 2'h1) |=> term_q == qdc_pkg::QDC_TERM_2K5)
        else $error("wrong power-down termination");
    chk_pd_term_100k: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (pd_cmd && frame.channel_select == 2'h2) |=> term_q == qdc_pkg::QDC_TERM_100K)
        else $error("wrong power-down termination for address two");
    chk_pd_term_hiz0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (pd_cmd && frame.channel_select == 2'h0) |=> term_q == qdc_pkg::QDC_TERM_HIZ)
        else $error("wrong power-down termination for address zero");
    chk_pd_term_hiz3: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (pd_cmd && frame.channel_select == 2'h3) |=> term_q == qdc_pkg::QDC_TERM_HIZ)
        else $error("wrong power-down termination for address three");
    chk_pd_exit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && pd_q && frame.mode != qdc_pkg::QDC_POWER_DOWN) |=> !pd_q)
        else $error("power-down not left by a write frame");
    chk_wake_wait: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $fell(pd_q) |-> !outputs_valid_o) else $error("outputs valid before wake delay");
    chk_wake_load: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $fell(pd_q) |-> wake_q == 16'(WAKE_CYCLES))
        else $error("wake counter not loaded on power-down exit");
    chk_load_all: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ALL)
        |=> latch_q[3] == $past(frame.code)) else $error("load-all missed a channel");
    chk_load_all_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ALL)
        |=> latch_q[0] == $past(frame.code)) else $error("load-all missed channel zero");
    chk_load_all_code: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ALL)
        |=> code_q[2] == $past(frame.code)) else $error("load-all missed code two");
    chk_defer_latch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ONLY) |=> $stable(latch_q[0]))
        else $error("deferred load moved an output");
    chk_defer_latch3: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ONLY) |=> $stable(latch_q[3]))
        else $error("deferred load moved output three");
    chk_defer_code: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_ONLY && frame.channel_select == 2'h0)
        |=> code_q[0] == $past(frame.code)) else $error("deferred load missed its code");
    chk_update_copy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_UPDATE && frame.channel_select != 2'h1)
        |=> latch_q[1] == $past(code_q[1])) else $error("update did not copy a held code");
    chk_update_new: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (ld_cmd && frame.mode == qdc_pkg::QDC_LOAD_UPDATE && frame.channel_select == 2'h2)
        |=> latch_q[2] == $past(frame.code)) else $error("update missed addressed channel");
    chk_reset_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !wrote_q |-> latch_q[0] == qdc_pkg::CODE_RESET)
        else $error("output moved before the first write");
    chk_wrote_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ld_cmd |=> wrote_q)
        else $error("completed frame not recorded");
endmodule : qdc_top
`default_nettype wire

// File: qdc_pkg.sv
// Constants, types and field layout of the quad converter serial control block.
// Assumes a single system clock domain; link pins are sampled by that clock.
// Behaviour
// - Frame select low starts sixteen-bit falling-edge capture.
// - Sixteenth falling edge executes the frame.
// - Edges after the sixteenth are ignored.
// - First two bits address one channel.
// - Next two bits choose the operation.
// - Ten data bits, MSB first, straight binary; last two bits ignored.
// - Early select rise discards the frame.
// - Mode eleven powers down all channels.
// - Address bits choose power-down termination.
// - Power-down leaves code registers unchanged.
// - Outputs valid only after wake delay.
// - Reset clears codes, outputs zero until write.
// - Each code is ten bits, zero to 1023.
package qdc_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int NUM_CH = 4;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 14;
    localparam int MODE_MSB = 13;
    localparam int MODE_LSB = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 2;
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int WAKE_DELAY_US = 39;
    localparam int WAKE_CYCLES = (WAKE_DELAY_US * (SYS_CLK_HZ / 1_000_000));
    localparam logic [9:0] CODE_RESET = 10'h000;
    typedef enum logic [1:0] {
        QDC_LOAD_ONLY = 2'h0,
        QDC_LOAD_UPDATE = 2'h1,
        QDC_LOAD_ALL = 2'h2,
        QDC_POWER_DOWN = 2'h3
    } qdc_mode_t;
    typedef enum logic [1:0] {
        QDC_TERM_HIZ,
        QDC_TERM_2K5,
        QDC_TERM_100K
    } qdc_term_t;
    typedef struct packed {
        logic [1:0] channel_select;
        qdc_mode_t mode;
        logic [9:0] code;
    } qdc_frame_t;
endpackage : qdc_pkg

// File: qdc_frame_rx.sv
// Serial frame receiver: samples the link pins, counts falling clock edges.
// Assumes link pins are asynchronous to sys_clk_i and slow against it.
`timescale 1ns/1ps
`default_nettype none
module qdc_frame_rx #(
    parameter int FRAME_LEN = qdc_pkg::FRAME_BITS
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic frame_sel_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    output logic frame_done_o,
    output qdc_pkg::qdc_frame_t frame_o,
    output logic frame_abort_o
);
    initial begin
        if (FRAME_LEN != 16) $error("qdc_frame_rx supports only 16-bit frames");
    end
    logic [1:0] sel_sync_q;
    logic [1:0] clk_sync_q;
    logic [1:0] dat_sync_q;
    logic clk_prev_q;
    logic sel_prev_q;
    logic [FRAME_LEN-1:0] shift_q;
    logic [4:0] count_q;
    logic done_q;
    logic abort_q;
    logic fall_edge;
    logic sel_low;
    // ==================================================
    // Pin synchronisers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_sync_q <= 2'h3;
            clk_sync_q <= 2'h0;
            dat_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end else if (clk_en_i) begin
            sel_sync_q <= {sel_sync_q[0], frame_sel_n_i};
            clk_sync_q <= {clk_sync_q[0], serial_clk_i};
            dat_sync_q <= {dat_sync_q[0], serial_data_i};
            clk_prev_q <= clk_sync_q[1];
            sel_prev_q <= sel_sync_q[1];
        end
    end
    assign sel_low = !sel_sync_q[1];
    assign fall_edge = clk_prev_q && !clk_sync_q[1];
    // ==================================================
    // Shift register and edge counter
    // falling-edge capture, capped
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q <= '0;
            count_q <= 5'h00;
        end else if (clk_en_i) begin
            if (!sel_low) begin
                count_q <= 5'h00;
            end else if (fall_edge && count_q < 5'(FRAME_LEN)) begin
                shift_q <= {shift_q[FRAME_LEN-2:0], dat_sync_q[1]};
                count_q <= count_q + 5'h01;
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (clk_en_i) begin
            done_q <= sel_low && fall_edge && count_q == 5'(FRAME_LEN - 1);
            abort_q <= sel_low == 1'b0 && sel_prev_q == 1'b0 && count_q != 5'(FRAME_LEN)
                       && count_q != 5'h00;
        end else begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
        end
    end
    assign frame_done_o = done_q;
    assign frame_abort_o = abort_q;
    assign frame_o.channel_select = shift_q[qdc_pkg::ADDR_MSB:qdc_pkg::ADDR_LSB];
    assign frame_o.mode = qdc_pkg::qdc_mode_t'(shift_q[qdc_pkg::MODE_MSB:qdc_pkg::MODE_LSB]);
    assign frame_o.code = shift_q[qdc_pkg::CODE_MSB:qdc_pkg::CODE_LSB];
    // counter never passes the frame length
    chk_count_capped: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        count_q <= 5'(FRAME_LEN)) else $error("edge counter passed frame length");
    chk_done_in_frame: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        done_q |-> $past(sel_low)) else $error("frame done outside select");
endmodule : qdc_frame_rx
`default_nettype wire

// File: qdc_host_model.sv
// Host model: drives the three-wire write link of the converter control.
// Assumes the caller waits for each send to return before starting another.
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model #(
    parameter int HALF_NS = 80
) (
    output logic frame_sel_n_o,
    output logic serial_clk_o,
    output logic serial_data_o
);
    // ==========================================================
    // Idle levels
    // idle pins low
    initial begin
        frame_sel_n_o = 1'b0;
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
    end

    // ==========================================================
    // Frame transmission
    // Sends the top n bits of w; one to fifteen bits makes an aborted frame.
    task automatic send(input logic [31:0] w, input int n);
        frame_sel_n_o = 1'b1;
        #(HALF_NS);
        frame_sel_n_o = 1'b0;
        #(HALF_NS);
        // MSB first, select low across bytes
        for (int i = 0; i < n; i++) begin
            serial_clk_o = 1'b1;
            serial_data_o = w[31-i];
            #(HALF_NS);
            serial_clk_o = 1'b0;
            #(HALF_NS);
        end
        frame_sel_n_o = 1'b1;
        #(HALF_NS);
        frame_sel_n_o = 1'b0;
        serial_data_o = 1'b0;
    endtask : send
endmodule : qdc_host_model
`default_nettype wire

// File: qdc_top_tb_top.sv
// Testbench of the quad converter control, driving it through a host model.
// Assumes the design's own assertions run alongside.
`timescale 1ns/1ps
`default_nettype none
module qdc_top_tb_top;
    localparam int WAKE = 40;
    logic sys_clk_i, nrst_i, sel_n, sclk, sdata, pd, valid, done, abort;
    logic [39:0] out_code;
    qdc_pkg::qdc_term_t term;
    int n_errors = 0, compares = 0, n_done = 0, n_abort = 0, cycles = 0;

    qdc_top #(.WAKE_CYCLES(WAKE)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
        .frame_sel_n_i(sel_n), .serial_clk_i(sclk), .serial_data_i(sdata),
        .out_code_o(out_code), .powered_down_o(pd), .term_o(term),
        .outputs_valid_o(valid), .frame_done_o(done), .frame_abort_o(abort));
    qdc_host_model host (.frame_sel_n_o(sel_n), .serial_clk_o(sclk), .serial_data_o(sdata));

    // ==========================================================
    // Clock, pulse counters and hang guard
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (done === 1'b1) n_done++;
        if (abort === 1'b1) n_abort++;
        if (cycles == 10000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic run_frame(input logic [1:0] ch, input qdc_pkg::qdc_mode_t md,
                             input logic [9:0] code, input int n);
        @(posedge sys_clk_i);
        #2;
        host.send({ch, md, code, 2'h3, 16'hffff}, n);
        repeat (8) @(posedge sys_clk_i);
    endtask : run_frame
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(out_code, 40'h0);
        chk({39'h0, pd}, 40'h0);
        chk({38'h0, term}, 40'h0);
        chk({39'h0, valid}, 40'h0);
    endtask : t_reset
    task automatic t_load();
        run_frame(2'h1, qdc_pkg::QDC_LOAD_ONLY, 10'h3ff, 16);
        chk(out_code, 40'h0);
        chk(n_done, 1);
        run_frame(2'h0, qdc_pkg::QDC_LOAD_UPDATE, 10'h155, 16);
        chk(out_code, {20'h0, 10'h3ff, 10'h155});
        repeat (WAKE + 4) @(posedge sys_clk_i);
        chk({39'h0, valid}, 40'h1);
    endtask : t_load
    task automatic t_all_extra();
        run_frame(2'h2, qdc_pkg::QDC_LOAD_ALL, 10'h200, 20);
        chk(out_code, {4{10'h200}});
        chk(n_done, 3);
        chk(n_abort, 0);
    endtask : t_all_extra
    task automatic t_abort();
        run_frame(2'h3, qdc_pkg::QDC_LOAD_UPDATE, 10'h0ab, 15);
        chk(n_abort, 1);
        chk(n_done, 3);
        chk(out_code, {4{10'h200}});
    endtask : t_abort
    task automatic t_power();
        qdc_pkg::qdc_term_t et;
        for (int a = 0; a < 4; a++) begin
            et = (a == 1) ? qdc_pkg::QDC_TERM_2K5 :
                 (a == 2) ? qdc_pkg::QDC_TERM_100K : qdc_pkg::QDC_TERM_HIZ;
            run_frame(a[1:0], qdc_pkg::QDC_POWER_DOWN, 10'h3ff, 16);
            chk({39'h0, pd}, 40'h1);
            chk({38'h0, term}, {38'h0, et});
            chk(out_code, {4{10'h200}});
            chk({39'h0, valid}, 40'h0);
        end
        run_frame(2'h3, qdc_pkg::QDC_LOAD_ONLY, 10'h011, 16);
        chk({39'h0, pd}, 40'h0);
        chk({39'h0, valid}, 40'h0);
        repeat (WAKE + 4) @(posedge sys_clk_i);
        chk({39'h0, valid}, 40'h1);
        run_frame(2'h0, qdc_pkg::QDC_LOAD_UPDATE, 10'h001, 16);
        chk(out_code, {10'h011, 10'h200, 10'h200, 10'h001});
    endtask : t_power

    initial begin
        nrst_i = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        #2;
        nrst_i = 1'b1;
        t_reset();
        t_load();
        t_all_extra();
        t_abort();
        t_power();
        print_verdict();
    end
endmodule : qdc_top_tb_top
`default_nettype wire
